// *** common/calib_trim_pkg.sv ***
package calib_trim_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [15:0] addr_calib_access_ctrl  = 16'h0070;
    localparam logic [15:0] addr_calib_vector_port  = 16'h0071;
    localparam logic [15:0] addr_gain_adjust_chan_a = 16'h007a;
    localparam logic [15:0] addr_gain_adjust_chan_b = 16'h007b;
    localparam logic [15:0] addr_bandgap_adjust     = 16'h007c;
    // own choice: streaming address-hold control and status
    localparam logic [15:0] addr_stream_ctrl        = 16'h0072;
    localparam logic [15:0] addr_calib_status       = 16'h0073;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int          access_en_bit     = 0;
    localparam int          addr_hold_bit     = 0;
    localparam int          bandgap_width     = 4;
    localparam logic [7:0]  access_ctrl_reset = 8'h00;
    localparam logic [7:0]  stream_ctrl_reset = 8'h00;
    localparam logic [7:0]  unmapped_value    = 8'h00;

    // status bit positions
    localparam int          st_halted_bit     = 0;
    localparam int          st_valid_bit      = 1;
    localparam int          st_busy_bit       = 2;

    // ------------------------------------------------------------
    // vector geometry
    // ------------------------------------------------------------
    localparam int          vector_len        = 673;
    localparam int          index_width       = 10;
    localparam logic [9:0]  index_last        = 10'h2a0;
    localparam logic [9:0]  index_zero        = 10'h000;
    localparam int          fifo_depth        = 4;
    localparam int          data_width        = 8;

endpackage

// *** common/vec_stream_if.sv ***
`timescale 1ns/1ps
// byte stream between the register front end and the fifo
interface vec_stream_if;
    logic       valid;   // byte offered
    logic       ready;   // byte accepted
    logic [7:0] data;    // byte payload

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface

// *** verilog/vec_fifo.sv ***
`timescale 1ns/1ps
module vec_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             sys_rst,
    // fill side
    vec_stream_if.sink            fill,
    // drain side
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready,
    // status
    output logic                  empty,
    output logic                  full
);
    localparam int AW = $clog2(DEPTH);

    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] mem_reg [DEPTH];  // flip-flop storage
    logic [AW-1:0]    wr_ptr_reg;       // write index
    logic [AW-1:0]    rd_ptr_reg;       // read index
    logic [AW:0]      count_reg;        // fill level
    logic             push;             // accepted write
    logic             pop;              // accepted read

    // fill level is one bit wider than the index, so depth itself is representable
    assign full       = (count_reg == (AW+1)'(DEPTH));
    assign empty      = (count_reg == '0);
    assign fill.ready = !full;
    assign out_valid  = !empty;
    assign out_data   = mem_reg[rd_ptr_reg];
    assign push       = fill.valid && !full;
    assign pop        = out_ready && !empty;

    // storage write
    always_ff @(posedge clock) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= fill.data;
        end
    end

    // pointers wrap at depth
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** verilog/halt_sync.sv ***
`timescale 1ns/1ps
module halt_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // async level in, synchronised level out
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;  // first stage, read only by second

    // two-stage synchroniser
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// *** verilog/calib_vector_and_trim_regs.sv ***
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module calib_vector_and_trim_regs (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    // streaming address hold to the serial front end
    output logic             addr_hold,
    // calibration engine status pin
    input  wire logic        calib_halted_pin,
    // factory values from fuse storage
    input  wire logic [7:0]  fuse_gain_a,
    input  wire logic [7:0]  fuse_gain_b,
    input  wire logic [3:0]  fuse_bandgap,
    input  wire logic        fuse_ready,
    // calibration vector storage side
    output logic             vec_wr_en,
    output logic [9:0]       vec_index,
    output logic [7:0]       vec_wr_data,
    input  wire logic [7:0]  vec_rd_data,
    // trim outputs to analog
    output logic [7:0]       gain_trim_a,
    output logic [7:0]       gain_trim_b,
    output logic [3:0]       bandgap_trim,
    // calibration state
    output logic             calib_valid
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {xfer_idle, xfer_read, xfer_write} xfer_state_t;

    xfer_state_t      xfer_reg;          // current transfer direction
    logic             access_en_reg;     // port enable bit
    logic             addr_hold_reg;     // stream address hold bit
    logic [9:0]       index_reg;         // vector byte index
    logic             valid_reg;         // vector consistent
    logic [7:0]       gain_a_reg;        // channel a gain trim
    logic [7:0]       gain_b_reg;        // channel b gain trim
    logic [3:0]       bandgap_reg;       // band-gap trim
    logic             fuse_done_reg;     // factory load done
    logic [7:0]       rdata_reg;         // read data, next cycle
    logic             calib_halted_flag; // synchronised halt status
    logic             port_hit;          // data port decoded
    logic             port_wr;           // accepted port write
    logic             port_rd;           // accepted port read
    logic             fifo_valid;        // fifo head valid
    logic [7:0]       fifo_data;         // fifo head byte
    logic             fifo_empty;        // fifo empty
    logic             vec_wr_en_reg;     // storage strobe
    logic [7:0]       vec_wr_data_reg;   // storage byte

    vec_stream_if     wr_stream ();      // write path into fifo

    // ------------------------------------------------------------
    // status input synchroniser
    // ------------------------------------------------------------
    halt_sync u_halt_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in (calib_halted_pin),
        .sync_out (calib_halted_flag)
    );

    // ------------------------------------------------------------
    // data port decode
    // ------------------------------------------------------------
    assign port_hit = (reg_addr == calib_trim_pkg::addr_calib_vector_port) && access_en_reg;
    // a full fifo refuses the write; the host is never stalled, so the byte is dropped
    assign port_wr  = port_hit && reg_wr && wr_stream.ready;
    assign port_rd  = port_hit && reg_rd;

    // write bytes are buffered toward the vector storage
    assign wr_stream.valid = port_hit && reg_wr;
    assign wr_stream.data  = reg_wdata;

    vec_fifo #(
        .WIDTH (calib_trim_pkg::data_width),
        .DEPTH (calib_trim_pkg::fifo_depth)
    ) u_vec_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .fill      (wr_stream.sink),
        .out_valid (fifo_valid),
        .out_data  (fifo_data),
        .out_ready (1'b1),
        .empty     (fifo_empty),
        .full      ()
    );

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // enable and address-hold bits; reserved bits not stored
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            access_en_reg <= calib_trim_pkg::access_ctrl_reset[calib_trim_pkg::access_en_bit];
            addr_hold_reg <= calib_trim_pkg::stream_ctrl_reset[calib_trim_pkg::addr_hold_bit];
        end else if (reg_wr) begin
            if (reg_addr == calib_trim_pkg::addr_calib_access_ctrl) begin
                access_en_reg <= reg_wdata[calib_trim_pkg::access_en_bit];
            end else if (reg_addr == calib_trim_pkg::addr_stream_ctrl) begin
                addr_hold_reg <= reg_wdata[calib_trim_pkg::addr_hold_bit];
            end
        end
    end

    // ------------------------------------------------------------
    // vector index and transfer tracking
    // ------------------------------------------------------------
    // index steps per access, wraps after the last byte, clears with enable
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            index_reg <= calib_trim_pkg::index_zero;
            xfer_reg  <= xfer_idle;
        end else if (!access_en_reg) begin
            index_reg <= calib_trim_pkg::index_zero;
            xfer_reg  <= xfer_idle;
        end else if (port_rd || port_wr) begin
            if (index_reg == calib_trim_pkg::index_last) begin
                index_reg <= calib_trim_pkg::index_zero;
                xfer_reg  <= xfer_idle;
            end else begin
                index_reg <= index_reg + 10'h001;
                xfer_reg  <= port_rd ? xfer_read : xfer_write;
            end
        end
    end

    // validity: lost on a partial sequence or an access while running
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            valid_reg <= 1'b1;
        end else begin
            case (xfer_reg)
                xfer_idle: begin
                    if ((port_rd || port_wr) && !calib_halted_flag) begin
                        valid_reg <= 1'b0;
                    end
                end
                xfer_read, xfer_write: begin
                    if (!access_en_reg) begin
                        valid_reg <= 1'b0;
                    end else if ((port_rd || port_wr) && !calib_halted_flag) begin
                        valid_reg <= 1'b0;
                    end else if (port_wr && index_reg == calib_trim_pkg::index_last) begin
                        valid_reg <= 1'b1;
                    end else if (port_rd && index_reg == calib_trim_pkg::index_last) begin
                        valid_reg <= 1'b1;
                    end
                end
                default: begin
                    valid_reg <= valid_reg;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // vector storage write from fifo
    // ------------------------------------------------------------
    // index leads the drained byte by the fifo latency; storage takes the
    // stream in order, so the write index is tracked by the storage side
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            vec_wr_en_reg   <= 1'b0;
            vec_wr_data_reg <= 8'h00;
        end else begin
            vec_wr_en_reg   <= fifo_valid;
            vec_wr_data_reg <= fifo_data;
        end
    end

    // ------------------------------------------------------------
    // trim registers
    // ------------------------------------------------------------
    // factory values are taken once, when fuse storage reports ready
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            gain_a_reg    <= 8'h00;
            gain_b_reg    <= 8'h00;
            bandgap_reg   <= 4'h0;
            fuse_done_reg <= 1'b0;
        end else if (!fuse_done_reg) begin
            if (fuse_ready) begin
                gain_a_reg    <= fuse_gain_a;
                gain_b_reg    <= fuse_gain_b;
                bandgap_reg   <= fuse_bandgap;
                fuse_done_reg <= 1'b1;
            end
        end else if (reg_wr) begin
            if (reg_addr == calib_trim_pkg::addr_gain_adjust_chan_a) begin
                gain_a_reg <= reg_wdata;
            end else if (reg_addr == calib_trim_pkg::addr_gain_adjust_chan_b) begin
                gain_b_reg <= reg_wdata;
            end else if (reg_addr == calib_trim_pkg::addr_bandgap_adjust) begin
                bandgap_reg <= reg_wdata[calib_trim_pkg::bandgap_width-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == calib_trim_pkg::addr_calib_access_ctrl) begin
                rdata_reg <= {7'h00, access_en_reg};
            end else if (reg_addr == calib_trim_pkg::addr_calib_vector_port) begin
                // storage content, meaningless until loaded
                rdata_reg <= access_en_reg ? vec_rd_data : calib_trim_pkg::unmapped_value;
            end else if (reg_addr == calib_trim_pkg::addr_stream_ctrl) begin
                rdata_reg <= {7'h00, addr_hold_reg};
            end else if (reg_addr == calib_trim_pkg::addr_calib_status) begin
                rdata_reg <= {5'h00, (xfer_reg != xfer_idle), valid_reg, calib_halted_flag};
            end else if (reg_addr == calib_trim_pkg::addr_gain_adjust_chan_a) begin
                rdata_reg <= gain_a_reg;
            end else if (reg_addr == calib_trim_pkg::addr_gain_adjust_chan_b) begin
                rdata_reg <= gain_b_reg;
            end else if (reg_addr == calib_trim_pkg::addr_bandgap_adjust) begin
                rdata_reg <= {4'h0, bandgap_reg};
            end else begin
                rdata_reg <= calib_trim_pkg::unmapped_value;
            end
        end else begin
            rdata_reg <= calib_trim_pkg::unmapped_value;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata    = rdata_reg;
    assign addr_hold    = addr_hold_reg;
    assign vec_index    = index_reg;
    assign vec_wr_en    = vec_wr_en_reg;
    assign vec_wr_data  = vec_wr_data_reg;
    assign gain_trim_a  = gain_a_reg;
    assign gain_trim_b  = gain_b_reg;
    assign bandgap_trim = bandgap_reg;
    assign calib_valid  = valid_reg;

    // the fifo never holds more than one byte, since it drains every cycle
    logic unused_empty;
    assign unused_empty = fifo_empty;

endmodule

// *** verification/calib_vector_and_trim_regs_chk.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// port-level checker for the calibration and trim register bank
// ------------------------------------------------------------
module calib_vector_and_trim_regs_chk (
    // clock and reset
    input wire logic        clock,
    input wire logic        sys_rst,
    // register port
    input wire logic [15:0] reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // stream and status
    input wire logic        addr_hold,
    input wire logic        calib_halted_pin,
    // factory values
    input wire logic [7:0]  fuse_gain_a,
    input wire logic [7:0]  fuse_gain_b,
    input wire logic [3:0]  fuse_bandgap,
    input wire logic        fuse_ready,
    // vector storage side
    input wire logic        vec_wr_en,
    input wire logic [9:0]  vec_index,
    input wire logic [7:0]  vec_wr_data,
    input wire logic [7:0]  vec_rd_data,
    // trims and state
    input wire logic [7:0]  gain_trim_a,
    input wire logic [7:0]  gain_trim_b,
    input wire logic [3:0]  bandgap_trim,
    input wire logic        calib_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic       vec_access; // access to enable or data port
    logic       mapped;     // address decodes to a register
    logic [3:0] since_reg;  // cycles since last vector access, saturating

    assign vec_access = (reg_rd || reg_wr) && (reg_addr == calib_trim_pkg::addr_calib_access_ctrl ||
                        reg_addr == calib_trim_pkg::addr_calib_vector_port);
    assign mapped = reg_addr inside {16'h0070, 16'h0071, 16'h0072, 16'h0073, 16'h007a, 16'h007b, 16'h007c};

    // saturating age of the last vector access, bounds index and valid moves
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            since_reg <= 4'hf;
        end else if (vec_access) begin
            since_reg <= 4'h0;
        end else if (since_reg != 4'hf) begin
            since_reg <= since_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    rdata_idle_a: assert property (reg_rdata != 8'h00 |-> $past(reg_rd))
        else $error("read data seen without a read strobe");
    unmapped_zero_a: assert property ($past(reg_rd) && !$past(mapped) |-> reg_rdata == 8'h00)
        else $error("unmapped read returned nonzero");
    index_range_a: assert property (vec_index <= calib_trim_pkg::index_last)
        else $error("vector index beyond last byte");
    read_byte_a: assert property ($past(reg_rd && reg_addr == calib_trim_pkg::addr_calib_vector_port)
        && vec_index != $past(vec_index) |-> reg_rdata == $past(vec_rd_data))
        else $error("port read did not return stored byte");
    write_byte_a: assert property (vec_wr_en |-> $past(reg_wr, 2) && $past(reg_wdata, 2) == vec_wr_data
        && $past(reg_addr, 2) == calib_trim_pkg::addr_calib_vector_port)
        else $error("storage write not matching port write");
    index_moves_a: assert property ($changed(vec_index) |-> since_reg <= 4'h3)
        else $error("index moved without vector access");
    valid_drop_a: assert property ($fell(calib_valid) |-> since_reg <= 4'h3)
        else $error("valid dropped without vector access");
    hold_write_a: assert property ($changed(addr_hold) |-> $past(reg_wr) && addr_hold == $past(reg_wdata[0])
        && $past(reg_addr) == calib_trim_pkg::addr_stream_ctrl)
        else $error("address hold changed without write");
    gain_a_src_a: assert property ($changed(gain_trim_a) |-> ($past(reg_wr) && gain_trim_a == $past(reg_wdata)
        && $past(reg_addr) == calib_trim_pkg::addr_gain_adjust_chan_a) || gain_trim_a == $past(fuse_gain_a))
        else $error("gain a changed from no source");
    bandgap_src_a: assert property ($changed(bandgap_trim) |-> ($past(reg_wr)
        && bandgap_trim == $past(reg_wdata[3:0]) && $past(reg_addr) == calib_trim_pkg::addr_bandgap_adjust)
        || bandgap_trim == $past(fuse_bandgap))
        else $error("band-gap trim changed from no source");
endmodule

bind calib_vector_and_trim_regs calib_vector_and_trim_regs_chk u_chk (.clock(clock), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .addr_hold(addr_hold), .calib_halted_pin(calib_halted_pin), .fuse_gain_a(fuse_gain_a),
    .fuse_gain_b(fuse_gain_b), .fuse_bandgap(fuse_bandgap), .fuse_ready(fuse_ready), .vec_wr_en(vec_wr_en),
    .vec_index(vec_index), .vec_wr_data(vec_wr_data), .vec_rd_data(vec_rd_data), .gain_trim_a(gain_trim_a),
    .gain_trim_b(gain_trim_b), .bandgap_trim(bandgap_trim), .calib_valid(calib_valid));

// *** verification/calib_vector_and_trim_regs_test.sv ***
`timescale 1ns/1ps
module calib_vector_and_trim_regs_test;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        addr_hold;
    logic        halted = 1'b1;       // calibration engine stopped
    logic        vec_wr_en;
    logic [9:0]  vec_index;
    logic [7:0]  vec_wr_data;
    logic [7:0]  vec_rd_data;         // storage model, byte per index
    logic [7:0]  gain_trim_a;
    logic [7:0]  gain_trim_b;
    logic [3:0]  bandgap_trim;
    logic        calib_valid;
    int          n_fail = 0;
    int          checked = 0;
    int          wr_seen = 0;         // storage writes observed
    int          cycles = 0;
    logic [7:0]  d;

    // storage content is a known pattern of the index
    assign vec_rd_data = vec_index[7:0] ^ 8'h5a;

    calib_vector_and_trim_regs dut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .addr_hold(addr_hold), .calib_halted_pin(halted), .fuse_gain_a(8'h3c), .fuse_gain_b(8'hc3),
        .fuse_bandgap(4'h9), .fuse_ready(1'b1), .vec_wr_en(vec_wr_en), .vec_index(vec_index),
        .vec_wr_data(vec_wr_data), .vec_rd_data(vec_rd_data), .gain_trim_a(gain_trim_a),
        .gain_trim_b(gain_trim_b), .bandgap_trim(bandgap_trim), .calib_valid(calib_valid));

    initial begin
        forever #2.5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_wr <= 1'b0;
        #1;  // leave the launching edge so registered outputs have settled
    endtask

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    // unload part or all of the vector, checking byte order
    task automatic unload(input int n);
        for (int i = 0; i < n; i++) begin
            rd_chk(16'h0071, i[7:0] ^ 8'h5a);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // restored bytes must reach storage in port order
    always @(posedge clock) begin
        if (vec_wr_en === 1'b1) begin
            chk(vec_wr_data, wr_seen[7:0] ^ 8'ha5);
            wr_seen++;
        end
    end

    // hang guard, well above the expected length of the run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            $display("Error at %0t: timeout", $time);
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        rd_chk(16'h007a, 8'h3c);
        rd_chk(16'h007b, 8'hc3);
        rd_chk(16'h007c, 8'h09);
        rd_chk(16'h0070, 8'h00);
        $display("reset values done");
        wr(16'h007a, 8'h81);
        wr(16'h007b, 8'h7e);
        wr(16'h007c, 8'hf6);
        rd_chk(16'h007a, 8'h81);
        rd_chk(16'h007b, 8'h7e);
        rd_chk(16'h007c, 8'h06);
        chk(bandgap_trim, 4'h6);
        chk(gain_trim_b, 8'h7e);
        $display("trim access done");
        rd_chk(16'h0071, 8'h00);
        wr(16'h0075, 8'hff);
        rd_chk(16'h0075, 8'h00);
        wr(16'h0072, 8'h01);
        chk(addr_hold, 1'b1);
        $display("refusals done");
        wr(16'h0070, 8'h01);
        unload(673);
        chk(vec_index, 10'h000);
        chk(calib_valid, 1'b1);
        for (int i = 0; i < 673; i++) begin
            wr(16'h0071, i[7:0] ^ 8'ha5);
        end
        repeat (4) @(posedge clock);
        chk(wr_seen[9:0], 10'd673);
        $display("full vector done");
        unload(5);
        wr(16'h0070, 8'h00);
        repeat (2) @(posedge clock);
        chk(calib_valid, 1'b0);
        chk(vec_index, 10'h000);
        wr(16'h0070, 8'h01);
        unload(673);
        chk(calib_valid, 1'b1);
        $display("short sequence done");
        halted <= 1'b0;
        repeat (4) @(posedge clock);
        rd(16'h0071, d);
        repeat (2) @(posedge clock);
        chk(calib_valid, 1'b0);
        rd_chk(16'h0073, 8'h04);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        chk(calib_valid, 1'b1);
        chk(gain_trim_a, 8'h3c);
        rd_chk(16'h0072, 8'h00);
        $display("unhalted access and reset done");
        tally_and_finish();
    end
endmodule
